// ### hw/rmc_pkg.sv
// Package for the main configuration register bank of the transceiver.
// Assumes a single 10 MHz system clock and a serial configuration port.
package rmc_pkg;
   // Register addresses, 5-bit address field
   localparam logic [4:0] ADDR_MODE_BAND = 5'h00;
   localparam logic [4:0] ADDR_DEV_LOW = 5'h01;
   localparam logic [4:0] ADDR_BIT_RATE = 5'h02;
   localparam logic [4:0] ADDR_LO_HIGH = 5'h03;
   localparam logic [4:0] ADDR_LO_LOW = 5'h04;
   localparam logic [4:0] MAIN_COUNT = 5'h05;
   // Other parameter groups, held elsewhere
   localparam logic [4:0] IRQ_FIRST = 5'h05;
   localparam logic [4:0] TX_FIRST = 5'h07;
   localparam logic [4:0] RX_FIRST = 5'h08;
   localparam logic [4:0] OSC_FIRST = 5'h11;
   localparam logic [4:0] TEST_FIRST = 5'h13;
   localparam logic [4:0] TEST_LAST = 5'h1e;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_ABSENT = 8'h00;
   // Fields of the mode and band register
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int SEL_BIT = 5;
   localparam int BUF_BIT = 4;
   localparam int UNIDIR_BIT = 3;
   localparam int BAND_HI = 2;
   localparam int BAND_LO = 1;
   localparam int DEV_MSB_BIT = 0;
   // Bit rate register
   localparam int FIXED_RATE_BIT = 7;
   localparam int DIV_HI = 6;
   localparam logic [6:0] DIV_IGNORED = 7'h00;
   // LO offset word
   localparam int LO_SIGN_433 = 14;
   localparam int LO_TOP = 15;
   // Address byte framing
   localparam int FRAME_START = 7;
   localparam int FRAME_RW = 6;
   localparam int FRAME_ADDR_HI = 5;
   localparam int FRAME_ADDR_LO = 1;
   localparam int FRAME_STOP = 0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Mode codes
   localparam logic [1:0] MODE_SLEEP = 2'h0;
   localparam logic [1:0] MODE_RX = 2'h1;
   localparam logic [1:0] MODE_TX = 2'h2;
   localparam logic [1:0] MODE_STBY = 2'h3;
   localparam logic [1:0] SW_OUT_SLEEP = 2'h0;
   localparam logic [1:0] SW_OUT_RX = 2'h1;
   localparam logic [1:0] SW_OUT_TX = 2'h2;
   localparam logic [1:0] SW_OUT_STBY = 2'h0;
   // Band codes
   localparam logic [1:0] BAND_433 = 2'h1;
   localparam logic [1:0] BAND_868 = 2'h2;
   localparam logic [1:0] BAND_915 = 2'h3;

   typedef enum logic {PH_ADDR, PH_DATA} rmc_phase_t;

   typedef struct packed {
      logic [2:0] sckS;
      logic [2:0] mosiS;
      logic [2:0] selS;
      logic [2:0][1:0] swS;
      logic sckLvl;
      logic mosiLvl;
      logic selLvl;
      logic [1:0] swLvl;
      rmc_phase_t phase;
      logic [2:0] bitCnt;
      logic frameOk;
      logic isRead;
      logic [4:0] addr;
      logic [7:0] shiftIn;
      logic [7:0] shiftOut;
      logic misoOe;
      logic [4:0][7:0] regs;
      logic [1:0] chipMode;
      logic [1:0] swOut;
      logic swOe;
      logic dataPinOe;
      logic dataPinIsInput;
      logic bufferedMode;
      logic [1:0] band;
      logic [8:0] freqDeviation;
      logic bitRateFixed;
      logic [6:0] bitRateDivisor;
      logic [15:0] loOffsetWord;
      logic loMid869;
   } rmc_state_t;
endpackage : rmc_pkg

// ### hw/rmc_main_config.sv
// Main parameter register bank with its serial configuration slave.
// Assumes port pins arrive asynchronously and serial clock stays under 2 MHz.
// What this block does
// [RULE1] Main group at 0-4; others not here
// [RULE2] Host writes zero to reserved bits
// [RULE3] Mode field: sleep, rx, tx, standby
// [RULE4] Register mode drives switch pins out
// [RULE5] Pin mode reads switch pins as inputs
// [RULE6] Bit 4 picks buffered or continuous path
// [RULE7] Data pin direction per unidirectional bit
// [RULE8] Band field selects frequency band
// [RULE9] Nine-bit deviation across addresses 0, 1
// [RULE10] Fixed-rate bit overrides rate divisor
// [RULE11] Seven-bit divisor sets bit rate
// [RULE12] LO offset word high/low bytes
// [RULE13] Low band: bit 14 is sign
// [RULE14] Middle band zero means 869 MHz
// [RULE15] Address byte framing, then data byte
// [RULE16] Select low spans alternating byte pairs
// [RULE17] Writes apply after full data byte
`timescale 1ns/1ps
module rmc_main_config (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration serial port
   input wire logic sck,
   input wire logic mosi,
   input wire logic configSelN,
   output logic miso,
   output logic misoOe,
   // Mode switch pins
   input wire logic [1:0] swIn,
   output logic [1:0] swOut,
   output logic swOe,
   // Data pin direction
   output logic dataPinOe,
   output logic dataPinIsInput,
   // Control outputs
   output logic [1:0] chipMode,
   output logic bufferedMode,
   output logic [1:0] band,
   output logic [8:0] freqDeviation,
   output logic bitRateFixed,
   output logic [6:0] bitRateDivisor,
   output logic [15:0] loOffsetWord,
   output logic loMid869
);
   logic rstMeta;
   logic rstSync;
   rmc_pkg::rmc_state_t r;
   rmc_pkg::rmc_state_t n;
   logic sckRise;
   logic sckFall;
   logic byteDone;
   logic wrEvt;
   logic [7:0] byteVal;
   logic [1:0] modeSel;
   logic [15:0] loRaw;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   always_comb begin
      n = r;
      sckRise = 1'b0;
      sckFall = 1'b0;
      byteDone = 1'b0;
      wrEvt = 1'b0;
      byteVal = r.shiftIn;
      modeSel = rmc_pkg::MODE_SLEEP;
      loRaw = 16'h0000;
      // Three-stage pin sampling; level moves once stages two and three agree
      n.sckS = {r.sckS[1:0], sck};
      n.mosiS = {r.mosiS[1:0], mosi};
      n.selS = {r.selS[1:0], configSelN};
      n.swS = {r.swS[1:0], swIn};
      if (r.sckS[1] == r.sckS[2]) begin
         n.sckLvl = r.sckS[2];
         sckRise = r.sckS[2] && !r.sckLvl;
         sckFall = !r.sckS[2] && r.sckLvl;
      end
      if (r.mosiS[1] == r.mosiS[2]) begin
         n.mosiLvl = r.mosiS[2];
      end
      if (r.selS[1] == r.selS[2]) begin
         n.selLvl = r.selS[2];
      end
      if (r.swS[1] == r.swS[2]) begin
         n.swLvl = r.swS[2];
      end
      // Deselect clears the counters; a cut byte must be resent
      if (r.selLvl) begin
         n.bitCnt = 3'h0; // [RULE16]
         n.phase = rmc_pkg::PH_ADDR; // [RULE16]
         n.misoOe = 1'b0;
      end else begin
         n.misoOe = 1'b1;
         if (sckRise) begin
            byteVal = {r.shiftIn[6:0], r.mosiLvl};
            n.shiftIn = byteVal;
            n.bitCnt = 3'(r.bitCnt + 3'h1);
            byteDone = (r.bitCnt == rmc_pkg::BIT_LAST);
         end else if (sckFall && r.bitCnt != 3'h0) begin
            // The fall closing a byte must not push out the MSB just loaded
            n.shiftOut = {r.shiftOut[6:0], 1'b0}; // [RULE15]
         end
      end
      if (byteDone) begin
         unique case (r.phase)
            rmc_pkg::PH_ADDR: begin
               // Malformed framing spoils the following data byte only
               n.frameOk = !byteVal[rmc_pkg::FRAME_START] && byteVal[rmc_pkg::FRAME_STOP]; // [RULE15]
               n.isRead = byteVal[rmc_pkg::FRAME_RW]; // [RULE15]
               n.addr = byteVal[rmc_pkg::FRAME_ADDR_HI:rmc_pkg::FRAME_ADDR_LO]; // [RULE15]
               n.shiftOut = rmc_pkg::READ_ABSENT;
               if (n.addr < rmc_pkg::MAIN_COUNT) begin
                  n.shiftOut = r.regs[n.addr[2:0]]; // [RULE1]
               end
               n.phase = rmc_pkg::PH_DATA; // [RULE16]
            end
            rmc_pkg::PH_DATA: begin
               wrEvt = r.frameOk && !r.isRead;
               // Other groups live elsewhere; their writes are dropped here
               if (wrEvt && r.addr < rmc_pkg::MAIN_COUNT) begin
                  n.regs[r.addr[2:0]] = byteVal; // [RULE1] [RULE17]
               end
               n.phase = rmc_pkg::PH_ADDR; // [RULE16]
            end
         endcase
      end
      // Decode from the next register image so a write lands with the byte
      if (n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::SEL_BIT]) begin
         modeSel = n.swLvl; // [RULE5]
         n.swOe = 1'b0; // [RULE5]
      end else begin
         modeSel = n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::MODE_HI:rmc_pkg::MODE_LO]; // [RULE3]
         n.swOe = 1'b1; // [RULE4]
      end
      n.chipMode = modeSel; // [RULE3]
      unique case (modeSel)
         rmc_pkg::MODE_SLEEP: n.swOut = rmc_pkg::SW_OUT_SLEEP; // [RULE4]
         rmc_pkg::MODE_RX: n.swOut = rmc_pkg::SW_OUT_RX; // [RULE4]
         rmc_pkg::MODE_TX: n.swOut = rmc_pkg::SW_OUT_TX; // [RULE4]
         rmc_pkg::MODE_STBY: n.swOut = rmc_pkg::SW_OUT_STBY; // [RULE4]
      endcase
      n.bufferedMode = n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::BUF_BIT]; // [RULE6]
      // Data pin drives only in receive; in transmit it listens or floats
      n.dataPinOe = (modeSel == rmc_pkg::MODE_RX); // [RULE7]
      n.dataPinIsInput = (modeSel == rmc_pkg::MODE_TX) &&
         !n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::UNIDIR_BIT]; // [RULE7]
      n.band = n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::BAND_HI:rmc_pkg::BAND_LO]; // [RULE8]
      n.freqDeviation = {n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::DEV_MSB_BIT],
         n.regs[rmc_pkg::ADDR_DEV_LOW]}; // [RULE9]
      n.bitRateFixed = n.regs[rmc_pkg::ADDR_BIT_RATE][rmc_pkg::FIXED_RATE_BIT]; // [RULE10]
      n.bitRateDivisor = n.bitRateFixed ? rmc_pkg::DIV_IGNORED :
         n.regs[rmc_pkg::ADDR_BIT_RATE][rmc_pkg::DIV_HI:0]; // [RULE10] [RULE11]
      loRaw = {n.regs[rmc_pkg::ADDR_LO_HIGH], n.regs[rmc_pkg::ADDR_LO_LOW]}; // [RULE12]
      // Low band word is 15 bits; top bit follows the sign
      if (n.band == rmc_pkg::BAND_433) begin
         loRaw[rmc_pkg::LO_TOP] = loRaw[rmc_pkg::LO_SIGN_433]; // [RULE13]
      end
      n.loOffsetWord = loRaw; // [RULE12]
      n.loMid869 = (n.band == rmc_pkg::BAND_868); // [RULE14]
   end

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         r <= '0;
         r.selS <= 3'h7;
         r.selLvl <= 1'b1;
         r.phase <= rmc_pkg::PH_ADDR;
         r.regs <= {5{rmc_pkg::REG_RESET}};
         r.swOe <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign miso = r.shiftOut[7];
   assign misoOe = r.misoOe;
   assign swOut = r.swOut;
   assign swOe = r.swOe;
   assign dataPinOe = r.dataPinOe;
   assign dataPinIsInput = r.dataPinIsInput;
   assign chipMode = r.chipMode;
   assign bufferedMode = r.bufferedMode;
   assign band = r.band;
   assign freqDeviation = r.freqDeviation;
   assign bitRateFixed = r.bitRateFixed;
   assign bitRateDivisor = r.bitRateDivisor;
   assign loOffsetWord = r.loOffsetWord;
   assign loMid869 = r.loMid869;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync);

   property p_reg_mode_out;
      !n.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::SEL_BIT] && modeSel == rmc_pkg::MODE_RX
         |=> swOe && swOut == rmc_pkg::SW_OUT_RX && chipMode == rmc_pkg::MODE_RX;
   endproperty
   a_reg_mode_out: assert property (p_reg_mode_out) else $error("register rx mode"); // [RULE4]

   property p_stby_out;
      swOe && chipMode == rmc_pkg::MODE_STBY |-> swOut == rmc_pkg::SW_OUT_STBY;
   endproperty
   a_stby_out: assert property (p_stby_out) else $error("standby pin code"); // [RULE4]

   property p_pin_mode;
      r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::SEL_BIT] |-> !swOe && chipMode == r.swLvl;
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin mode not followed"); // [RULE5]

   property p_data_dir;
      (chipMode == rmc_pkg::MODE_TX |-> !dataPinOe) and
      (chipMode == rmc_pkg::MODE_RX |-> dataPinOe && !dataPinIsInput);
   endproperty
   a_data_dir: assert property (p_data_dir) else $error("data pin direction"); // [RULE7]

   property p_write_dev;
      wrEvt && r.addr == rmc_pkg::ADDR_DEV_LOW |=> freqDeviation[7:0] == $past(byteVal);
   endproperty
   a_write_dev: assert property (p_write_dev) else $error("deviation write lost"); // [RULE17]

   property p_write_buf;
      wrEvt && r.addr == rmc_pkg::ADDR_MODE_BAND
         |=> bufferedMode == $past(byteVal[rmc_pkg::BUF_BIT]);
   endproperty
   a_write_buf: assert property (p_write_buf) else $error("buffered bit write lost"); // [RULE6]

   property p_foreign_addr;
      wrEvt && r.addr >= rmc_pkg::MAIN_COUNT |=> $stable(r.regs);
   endproperty
   a_foreign_addr: assert property (p_foreign_addr) else $error("foreign write hit bank"); // [RULE1]

   property p_bad_frame;
      byteDone && r.phase == rmc_pkg::PH_ADDR
         && (byteVal[rmc_pkg::FRAME_START] || !byteVal[rmc_pkg::FRAME_STOP])
         |=> !r.frameOk ##0 r.phase == rmc_pkg::PH_DATA;
   endproperty
   a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted"); // [RULE15]

   property p_deselect;
      r.selLvl |=> r.bitCnt == 3'h0 && r.phase == rmc_pkg::PH_ADDR && !misoOe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("counters not cleared"); // [RULE16]

   property p_fixed_rate;
      bitRateFixed |-> bitRateDivisor == rmc_pkg::DIV_IGNORED;
   endproperty
   a_fixed_rate: assert property (p_fixed_rate) else $error("divisor not ignored"); // [RULE10]

   property p_lo_sign;
      band == rmc_pkg::BAND_433 |-> loOffsetWord[rmc_pkg::LO_TOP] == loOffsetWord[rmc_pkg::LO_SIGN_433];
   endproperty
   a_lo_sign: assert property (p_lo_sign) else $error("low band sign"); // [RULE13]

   property p_mid869;
      loMid869 == (band == rmc_pkg::BAND_868);
   endproperty
   a_mid869: assert property (p_mid869) else $error("869 centre flag"); // [RULE14]

   property p_keep_msb;
      sckFall && r.bitCnt == 3'h0 |=> $stable(r.shiftOut);
   endproperty
   a_keep_msb: assert property (p_keep_msb) else $error("read MSB shifted away"); // [RULE15]

   property p_absent_read;
      byteDone && r.phase == rmc_pkg::PH_ADDR
         && byteVal[rmc_pkg::FRAME_ADDR_HI:rmc_pkg::FRAME_ADDR_LO] >= rmc_pkg::MAIN_COUNT
         |=> r.shiftOut == rmc_pkg::READ_ABSENT;
   endproperty
   a_absent_read: assert property (p_absent_read) else $error("foreign read not zero"); // [RULE1]

   property p_reg_mode;
      !r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::SEL_BIT] |-> swOe
         && chipMode == r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::MODE_HI:rmc_pkg::MODE_LO];
   endproperty
   a_reg_mode: assert property (p_reg_mode) else $error("register mode not followed"); // [RULE3]

   property p_buf_path;
      bufferedMode == r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::BUF_BIT];
   endproperty
   a_buf_path: assert property (p_buf_path) else $error("data path select"); // [RULE6]

   property p_band;
      band == r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::BAND_HI:rmc_pkg::BAND_LO];
   endproperty
   a_band: assert property (p_band) else $error("band field"); // [RULE8]

   property p_deviation;
      freqDeviation == {r.regs[rmc_pkg::ADDR_MODE_BAND][rmc_pkg::DEV_MSB_BIT],
         r.regs[rmc_pkg::ADDR_DEV_LOW]};
   endproperty
   a_deviation: assert property (p_deviation) else $error("deviation count"); // [RULE9]

   property p_divisor;
      !bitRateFixed |-> bitRateDivisor == r.regs[rmc_pkg::ADDR_BIT_RATE][rmc_pkg::DIV_HI:0];
   endproperty
   a_divisor: assert property (p_divisor) else $error("rate divisor"); // [RULE11]

   property p_lo_word;
      band != rmc_pkg::BAND_433
         |-> loOffsetWord == {r.regs[rmc_pkg::ADDR_LO_HIGH], r.regs[rmc_pkg::ADDR_LO_LOW]};
   endproperty
   a_lo_word: assert property (p_lo_word) else $error("LO offset word"); // [RULE12]

   c_write: cover property (wrEvt ##1 !r.selLvl);
   c_read: cover property (byteDone && r.phase == rmc_pkg::PH_DATA && r.isRead);
   c_pin_tx: cover property (!swOe && chipMode == rmc_pkg::MODE_TX);
   c_b2b: cover property (wrEvt ##[1:200] wrEvt);
   c_bad_start: cover property (byteDone && r.phase == rmc_pkg::PH_ADDR && byteVal[rmc_pkg::FRAME_START]);
endmodule : rmc_main_config

// ### tb/rmc_spi_master.sv
// Serial master model for the configuration port of the register bank.
// Assumes the bench calls its tasks; pins change only on falling clk edges.
`timescale 1ns/1ps
module rmc_spi_master (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sck,
   output logic mosi,
   output logic configSelN,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      configSelN = 1'b1;
   end
   // Select edge, then a gap so the pin filter settles
   task automatic sel(input logic lvl);
      @(negedge clk);
      configSelN = lvl;
      if (lvl) begin
         mosi = ~mosi;
      end
      repeat (5) @(negedge clk);
   endtask : sel
   // Half period of 5 clk: sck stays far below 2 MHz for the 3-flop filter
   task automatic xbyte(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         @(negedge clk);
         sck = 1'b0;
         mosi = tx[i];
         repeat (5) @(negedge clk);
         sck = 1'b1;
         rx[i] = miso;
         repeat (4) @(negedge clk);
      end
      @(negedge clk);
      sck = 1'b0;
   endtask : xbyte
   // Address byte then data byte; reads send zeros
   task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      logic [7:0] dummy;
      xbyte({1'b0, rd, a, 1'b1}, 8, dummy);
      xbyte(rd ? 8'h00 : d, 8, q);
   endtask : access
endmodule : rmc_spi_master

// ### tb/rmc_main_config_bench.sv
// Self-checking bench for the main configuration register bank.
// Assumes a 10 MHz clock; all registers reset to zero.
`timescale 1ns/1ps
module rmc_main_config_bench;
   typedef struct {logic [4:0] a; logic [7:0] d; int f; logic [15:0] e;} rmc_row_t;
   logic clk;
   logic rst_n;
   logic sck, mosi, configSelN, miso, misoOe, swOe, dataPinOe, dataPinIsInput;
   logic bufferedMode, bitRateFixed, loMid869;
   logic [1:0] swIn, swOut, chipMode, band;
   logic [1:0] swDrv;
   logic [8:0] freqDeviation;
   logic [6:0] bitRateDivisor;
   logic [15:0] loOffsetWord;
   logic [7:0] q;
   logic misoBus;
   int n_fail = 0;
   int cmp_count = 0;
   // Rows: write one register, then look at one output
   rmc_row_t rows [28] = '{
      '{5'h00, 8'h40, 0, 16'h1}, '{5'h00, 8'h40, 1, 16'h1}, '{5'h00, 8'h40, 3, 16'h1},
      '{5'h00, 8'h80, 0, 16'h2}, '{5'h00, 8'h80, 1, 16'h2}, '{5'h00, 8'h80, 4, 16'h1},
      '{5'h00, 8'h88, 4, 16'h0}, '{5'h00, 8'h88, 3, 16'h0}, '{5'h00, 8'hc0, 0, 16'h3},
      '{5'h00, 8'hc0, 1, 16'h0}, '{5'h00, 8'hc0, 2, 16'h1}, '{5'h00, 8'h10, 5, 16'h1},
      '{5'h00, 8'h01, 5, 16'h0}, '{5'h00, 8'h01, 7, 16'h100}, '{5'h01, 8'hff, 7, 16'h1ff},
      '{5'h00, 8'h04, 7, 16'h0ff}, '{5'h00, 8'h04, 6, 16'h2}, '{5'h00, 8'h04, 11, 16'h1},
      '{5'h02, 8'h85, 8, 16'h1}, '{5'h02, 8'h85, 9, 16'h0}, '{5'h02, 8'h7f, 9, 16'h7f},
      '{5'h02, 8'h7f, 8, 16'h0}, '{5'h03, 8'h80, 10, 16'h8000}, '{5'h04, 8'h01, 10, 16'h8001},
      '{5'h00, 8'h02, 10, 16'h0001}, '{5'h03, 8'h40, 10, 16'hc001},
      '{5'h00, 8'h06, 11, 16'h0}, '{5'h00, 8'h06, 6, 16'h3}};
   // Switch pins: whoever has the enable drives the wire
   assign swIn = swOe ? swOut : swDrv;
   // Released data-out line shows the inverse, so a late enable spoils reads
   assign misoBus = misoOe ? miso : ~miso;
   rmc_main_config dut (.clk(clk), .rst_n(rst_n), .sck(sck), .mosi(mosi),
      .configSelN(configSelN), .miso(miso), .misoOe(misoOe), .swIn(swIn), .swOut(swOut),
      .swOe(swOe), .dataPinOe(dataPinOe), .dataPinIsInput(dataPinIsInput),
      .chipMode(chipMode), .bufferedMode(bufferedMode), .band(band),
      .freqDeviation(freqDeviation), .bitRateFixed(bitRateFixed),
      .bitRateDivisor(bitRateDivisor), .loOffsetWord(loOffsetWord), .loMid869(loMid869));
   rmc_spi_master m (.clk(clk), .sck(sck), .mosi(mosi), .configSelN(configSelN),
      .miso(misoBus));
   always #50 clk = ~clk;
   function automatic logic [15:0] obs(input int f);
      case (f)
         0: obs = 16'(chipMode);
         1: obs = 16'(swOut);
         2: obs = 16'(swOe);
         3: obs = 16'(dataPinOe);
         4: obs = 16'(dataPinIsInput);
         5: obs = 16'(bufferedMode);
         6: obs = 16'(band);
         7: obs = 16'(freqDeviation);
         8: obs = 16'(bitRateFixed);
         9: obs = 16'(bitRateDivisor);
         10: obs = loOffsetWord;
         default: obs = 16'(loMid869);
      endcase
   endfunction : obs
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      m.sel(1'b0);
      m.access(1'b0, a, d, q);
      m.sel(1'b1);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      m.sel(1'b0);
      m.access(1'b1, a, 8'h00, q);
      m.sel(1'b1);
      chk(16'(q), 16'(exp));
   endtask : rd
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   // Whole run needs about 7200 clk; the limit leaves ample room
   initial begin
      #2000000;
      n_fail++;
      end_sim();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      swDrv = 2'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk(16'(chipMode), 16'h0);
      chk(16'(swOe), 16'h1);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(obs(rows[i].f), rows[i].e);
      end
      $display("test table done");
      rd(5'h00, 8'h06);
      rd(5'h03, 8'h40);
      rd(5'h04, 8'h01);
      wr(5'h07, 8'hff);
      rd(5'h07, 8'h00);
      rd(5'h05, 8'h00);
      $display("test readback done");
      // Start bit set, then stop bit cleared: both data bytes must be dropped
      m.sel(1'b0);
      m.xbyte(8'h81, 8, q);
      m.xbyte(8'h40, 8, q);
      m.xbyte(8'h00, 8, q);
      m.xbyte(8'h46, 8, q);
      m.sel(1'b1);
      chk(16'(chipMode), 16'h0);
      m.sel(1'b0);
      m.access(1'b0, 5'h02, 8'h11, q);
      m.access(1'b0, 5'h01, 8'h22, q);
      m.sel(1'b1);
      chk(16'(bitRateDivisor), 16'h11);
      chk(16'(freqDeviation), 16'h022);
      // Select dropped mid-byte: the next byte is an address again
      m.sel(1'b0);
      m.xbyte(8'h04, 4, q);
      m.sel(1'b1);
      wr(5'h02, 8'h05);
      chk(16'(bitRateDivisor), 16'h05);
      $display("test framing done");
      wr(5'h00, 8'h20);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         swDrv = 2'(k);
         repeat (8) @(negedge clk);
         chk(16'(chipMode), 16'(k));
         chk(16'(swOe), 16'h0);
      end
      $display("test pin mode done");
      // Reset in mid-run: bank and pins return to their idle values
      @(negedge clk);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(16'(chipMode), 16'h0);
      chk(16'(swOe), 16'h1);
      chk(loOffsetWord, 16'h0000);
      rd(5'h02, 8'h00);
      chk(16'(misoOe), 16'h0);
      $display("test mid reset done");
      end_sim();
   end
endmodule : rmc_main_config_bench
